//--- hdl/uart_ctl_top.sv
// serial port control plane: registers, enables, DMA requests, infrared codec, interrupts
`timescale 1ns/1ps
module uart_ctl_top #(
    parameter int DEPTH     = 16,
    parameter int LVL_W     = 5,
    parameter int LP_CYCLES = uart_ctl_pkg::IR_LP_PULSE_CYC
) (
    // clock and reset
    input  wire logic             REF_CLK_I,
    input  wire logic             RST_N_I,
    // APB slave
    input  wire logic             PSEL_I,
    input  wire logic             PENABLE_I,
    input  wire logic             PWRITE_I,
    input  wire logic [7:0]       PADDR_I,
    input  wire logic [31:0]      PWDATA_I,
    output logic [31:0]           PRDATA_O,
    output logic                  PREADY_O,
    output logic                  PSLVERR_O,
    // framer and FIFO status
    input  wire logic [LVL_W-1:0] TX_LEVEL_I,
    input  wire logic [LVL_W-1:0] RX_LEVEL_I,
    input  wire logic             TX_BUSY_I,
    input  wire logic             TX_SERIAL_I,
    input  wire logic             BAUD16_TICK_I,
    // receive event pulses
    input  wire logic             EVT_ADDR_MATCH_I,
    input  wire logic             EVT_OVERRUN_I,
    input  wire logic             EVT_BREAK_I,
    input  wire logic             EVT_PARITY_I,
    input  wire logic             EVT_FRAMING_I,
    input  wire logic             EVT_TIMEOUT_I,
    // pins
    input  wire logic             RXD_I,
    input  wire logic             DSR_N_I,
    input  wire logic             DCD_N_I,
    input  wire logic             CTS_N_I,
    input  wire logic             RI_N_I,
    output logic                  TXD_O,
    // datapath control
    output logic                  TX_ENABLE_O,
    output logic                  RX_ENABLE_O,
    output logic                  FIFO_ENABLE_O,
    output logic                  TX_FLUSH_O,
    output logic                  RX_SERIAL_O,
    // DMA requests
    output logic                  TX_DMA_REQ_O,
    output logic                  RX_DMA_REQ_O,
    // interrupt
    output logic                  IRQ_O
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [uart_ctl_pkg::CTRL_W-1:0]    ctrl;
    logic [uart_ctl_pkg::DMA_W-1:0]     dmactl;
    logic [uart_ctl_pkg::LVL_SEL_W-1:0] tx_sel;
    logic [uart_ctl_pkg::LVL_SEL_W-1:0] rx_sel;
    logic [uart_ctl_pkg::IRQ_W-1:0]     irq_mask;
    logic [uart_ctl_pkg::IRQ_W-1:0]     irq_raw;
    logic [uart_ctl_pkg::IRQ_W-1:0]     irq_masked;
    logic [uart_ctl_pkg::IRQ_W-1:0]     irq_set;
    logic [uart_ctl_pkg::IRQ_W-1:0]     irq_clr;

    logic port_global_enable;
    logic transmitter_enable;
    logic receiver_enable;
    logic fifo_enable;
    logic infrared_mode_enable;
    logic infrared_low_power;
    logic rx_dma_enable;
    logic tx_dma_enable;
    logic rx_dma_stop_on_error;

    assign port_global_enable   = ctrl[uart_ctl_pkg::CTRL_GLOBAL];
    assign transmitter_enable   = ctrl[uart_ctl_pkg::CTRL_TX];
    assign receiver_enable      = ctrl[uart_ctl_pkg::CTRL_RX];
    assign fifo_enable          = ctrl[uart_ctl_pkg::CTRL_FIFO];
    assign infrared_mode_enable = ctrl[uart_ctl_pkg::CTRL_IR];
    assign infrared_low_power   = ctrl[uart_ctl_pkg::CTRL_IR_LP];
    assign rx_dma_enable        = dmactl[uart_ctl_pkg::DMA_RX];
    assign tx_dma_enable        = dmactl[uart_ctl_pkg::DMA_TX];
    assign rx_dma_stop_on_error = dmactl[uart_ctl_pkg::DMA_STOP];

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    logic setup_ph;
    logic wr_en;
    logic addr_ok;

    assign setup_ph  = PSEL_I & ~PENABLE_I;
    assign wr_en     = PSEL_I & PENABLE_I & PWRITE_I;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

    always_comb begin
        if (PADDR_I == uart_ctl_pkg::OFF_CTRL) begin
            addr_ok = 1'b1;
        end else if (PADDR_I == uart_ctl_pkg::OFF_DMACTL) begin
            addr_ok = 1'b1;
        end else if (PADDR_I == uart_ctl_pkg::OFF_LEVEL) begin
            addr_ok = 1'b1;
        end else if (PADDR_I == uart_ctl_pkg::OFF_MASK) begin
            addr_ok = 1'b1;
        end else if (PADDR_I == uart_ctl_pkg::OFF_RAW || PADDR_I == uart_ctl_pkg::OFF_MSKD) begin
            addr_ok = ~PWRITE_I;
        end else if (PADDR_I == uart_ctl_pkg::OFF_CLEAR) begin
            addr_ok = PWRITE_I;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // whole-word writes; each bit keeps the value software wrote
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl     <= uart_ctl_pkg::CTRL_RESET;
            dmactl   <= uart_ctl_pkg::DMA_RESET;
            tx_sel   <= uart_ctl_pkg::LVL_RESET;
            rx_sel   <= uart_ctl_pkg::LVL_RESET;
            irq_mask <= '0;
        end else if (wr_en) begin
            if (PADDR_I == uart_ctl_pkg::OFF_CTRL) begin
                ctrl <= PWDATA_I[uart_ctl_pkg::CTRL_W-1:0];
            end else if (PADDR_I == uart_ctl_pkg::OFF_DMACTL) begin
                dmactl <= PWDATA_I[uart_ctl_pkg::DMA_W-1:0];
            end else if (PADDR_I == uart_ctl_pkg::OFF_LEVEL) begin
                tx_sel <= PWDATA_I[uart_ctl_pkg::LVL_TX_LSB +: uart_ctl_pkg::LVL_SEL_W];
                rx_sel <= PWDATA_I[uart_ctl_pkg::LVL_RX_LSB +: uart_ctl_pkg::LVL_SEL_W];
            end else if (PADDR_I == uart_ctl_pkg::OFF_MASK) begin
                irq_mask <= PWDATA_I[uart_ctl_pkg::IRQ_W-1:0];
            end
        end
    end

    assign irq_clr = (wr_en && PADDR_I == uart_ctl_pkg::OFF_CLEAR) ?
                     PWDATA_I[uart_ctl_pkg::IRQ_W-1:0] : '0;

    // read data latched in the setup cycle, valid through the access cycle
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PRDATA_O <= '0;
        end else if (setup_ph) begin
            PRDATA_O <= '0;
            if (PWRITE_I) begin
                PRDATA_O <= '0;
            end else if (PADDR_I == uart_ctl_pkg::OFF_CTRL) begin
                PRDATA_O[uart_ctl_pkg::CTRL_W-1:0] <= ctrl;
            end else if (PADDR_I == uart_ctl_pkg::OFF_DMACTL) begin
                PRDATA_O[uart_ctl_pkg::DMA_W-1:0] <= dmactl;
            end else if (PADDR_I == uart_ctl_pkg::OFF_LEVEL) begin
                PRDATA_O[uart_ctl_pkg::LVL_TX_LSB +: uart_ctl_pkg::LVL_SEL_W] <= tx_sel;
                PRDATA_O[uart_ctl_pkg::LVL_RX_LSB +: uart_ctl_pkg::LVL_SEL_W] <= rx_sel;
            end else if (PADDR_I == uart_ctl_pkg::OFF_MASK) begin
                PRDATA_O[uart_ctl_pkg::IRQ_W-1:0] <= irq_mask;
            end else if (PADDR_I == uart_ctl_pkg::OFF_RAW) begin
                PRDATA_O[uart_ctl_pkg::IRQ_W-1:0] <= irq_raw;
            end else if (PADDR_I == uart_ctl_pkg::OFF_MSKD) begin
                PRDATA_O[uart_ctl_pkg::IRQ_W-1:0] <= irq_masked;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic [4:0] pin_prev;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_meta <= 5'h1f;
            pin_sync <= 5'h1f;
            pin_prev <= 5'h1f;
        end else begin
            pin_meta <= {RXD_I, DSR_N_I, DCD_N_I, CTS_N_I, RI_N_I};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit enable with finish-then-flush on disable
    logic tx_req;
    logic tx_run;

    assign tx_req = port_global_enable & transmitter_enable;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tx_run     <= 1'b0;
            TX_FLUSH_O <= 1'b0;
        end else begin
            tx_run     <= tx_req | (tx_run & TX_BUSY_I);
            TX_FLUSH_O <= tx_run & ~tx_req & ~TX_BUSY_I;
        end
    end

    assign TX_ENABLE_O   = tx_run;
    assign RX_ENABLE_O   = port_global_enable & receiver_enable;
    assign FIFO_ENABLE_O = fifo_enable;

    ////////////////////////////////////////////////////////////////////////
    // DMA requests
    logic tx_space;
    logic rx_data;
    logic rx_err_hold;

    assign tx_space    = fifo_enable ? (TX_LEVEL_I < LVL_W'(DEPTH)) : (TX_LEVEL_I == '0);
    assign rx_data     = (RX_LEVEL_I != '0);
    assign rx_err_hold = rx_dma_stop_on_error & |(irq_raw & uart_ctl_pkg::IRQ_RX_ERR);
    assign TX_DMA_REQ_O = tx_dma_enable & tx_run & tx_space;
    assign RX_DMA_REQ_O = rx_dma_enable & RX_ENABLE_O & rx_data & ~rx_err_hold;

    ////////////////////////////////////////////////////////////////////////
    // infrared transmit modulation
    logic [3:0]  tx_phase;
    logic        tx_bit_q;
    logic [15:0] lp_cnt;
    logic        ir_pulse;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tx_phase <= '0;
            tx_bit_q <= 1'b1;
        end else begin
            tx_bit_q <= TX_SERIAL_I;
            if (TX_SERIAL_I != tx_bit_q) begin
                tx_phase <= '0;
            end else if (BAUD16_TICK_I) begin
                tx_phase <= tx_phase + 4'h1;
            end
        end
    end

    // low-power pulse has a fixed width independent of the baud rate
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lp_cnt <= '0;
        end else if (!TX_SERIAL_I && tx_phase == '0 && BAUD16_TICK_I && lp_cnt == '0) begin
            lp_cnt <= 16'(LP_CYCLES);
        end else if (lp_cnt != '0) begin
            lp_cnt <= lp_cnt - 16'h1;
        end
    end

    always_comb begin
        if (TX_SERIAL_I) begin
            ir_pulse = 1'b0;
        end else if (infrared_low_power) begin
            ir_pulse = (lp_cnt != '0);
        end else begin
            ir_pulse = (tx_phase < 4'(uart_ctl_pkg::IR_PULSE_TICKS));
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TXD_O <= 1'b1;
        end else if (!port_global_enable) begin
            TXD_O <= ~infrared_mode_enable;
        end else if (infrared_mode_enable) begin
            TXD_O <= ir_pulse & tx_run;
        end else begin
            TXD_O <= TX_SERIAL_I | ~tx_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // infrared receive demodulation: a low pulse stretches into one zero bit
    logic [4:0] rx_stretch;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rx_stretch <= '0;
        end else if (pin_prev[4] && !pin_sync[4]) begin
            rx_stretch <= 5'(uart_ctl_pkg::TICKS_PER_BIT);
        end else if (BAUD16_TICK_I && rx_stretch != '0) begin
            rx_stretch <= rx_stretch - 5'h1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RX_SERIAL_O <= 1'b1;
        end else if (infrared_mode_enable) begin
            RX_SERIAL_O <= (rx_stretch == '0);
        end else begin
            RX_SERIAL_O <= pin_sync[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt sources
    logic tx_cross;
    logic rx_cross;

    uart_fifo_threshold #(
        .DEPTH   (DEPTH),
        .LVL_W   (LVL_W),
        .TX_SIDE (1'b1)
    ) u_tx_thr (
        .clk_i     (REF_CLK_I),
        .rst_n_i   (RST_N_I),
        .fifo_en_i (fifo_enable),
        .sel_i     (tx_sel),
        .level_i   (TX_LEVEL_I),
        .crossed_o (tx_cross)
    );

    uart_fifo_threshold #(
        .DEPTH   (DEPTH),
        .LVL_W   (LVL_W),
        .TX_SIDE (1'b0)
    ) u_rx_thr (
        .clk_i     (REF_CLK_I),
        .rst_n_i   (RST_N_I),
        .fifo_en_i (fifo_enable),
        .sel_i     (rx_sel),
        .level_i   (RX_LEVEL_I),
        .crossed_o (rx_cross)
    );

    always_comb begin
        irq_set = '0;
        irq_set[uart_ctl_pkg::IRQ_RING]       = pin_sync[0] ^ pin_prev[0];
        irq_set[uart_ctl_pkg::IRQ_CTS]        = pin_sync[1] ^ pin_prev[1];
        irq_set[uart_ctl_pkg::IRQ_DCD]        = pin_sync[2] ^ pin_prev[2];
        irq_set[uart_ctl_pkg::IRQ_DSR]        = pin_sync[3] ^ pin_prev[3];
        irq_set[uart_ctl_pkg::IRQ_RX]         = rx_cross;
        irq_set[uart_ctl_pkg::IRQ_TX]         = tx_cross;
        irq_set[uart_ctl_pkg::IRQ_TIMEOUT]    = EVT_TIMEOUT_I;
        irq_set[uart_ctl_pkg::IRQ_FRAMING]    = EVT_FRAMING_I;
        irq_set[uart_ctl_pkg::IRQ_PARITY]     = EVT_PARITY_I;
        irq_set[uart_ctl_pkg::IRQ_BREAK]      = EVT_BREAK_I;
        irq_set[uart_ctl_pkg::IRQ_OVERRUN]    = EVT_OVERRUN_I;
        irq_set[uart_ctl_pkg::IRQ_ADDR_MATCH] = EVT_ADDR_MATCH_I;
    end

    uart_irq_status #(
        .W (uart_ctl_pkg::IRQ_W)
    ) u_irq (
        .clk_i    (REF_CLK_I),
        .rst_n_i  (RST_N_I),
        .set_i    (irq_set),
        .clr_i    (irq_clr),
        .mask_i   (irq_mask),
        .raw_o    (irq_raw),
        .masked_o (irq_masked),
        .irq_o    (IRQ_O)
    );

endmodule

//--- hdl/uart_ctl_pkg.sv
// constants, field layouts and types for the serial port control plane
// Function
// - separate enables for receive and transmit DMA requests
// - optional stop of receive DMA requests once a receive error is flagged
// - DMA control bits are written together; a write replaces all three
// - global, transmit and receive enable bits; FIFOs have their own enable bit
// - infrared mode bit selects infrared modulation and demodulation
// - separate low-power bit selects the low-power infrared pulse
// - one FIFO enable for both FIFOs; off means single-character holding
// - transmit threshold of one, two, four, six or seven eighths
// - receive threshold selectable on its own among the same five levels
// - threshold settings read back exactly as written
// - clearing named interrupt sources leaves other sources untouched
// - only unmasked sources drive the combined interrupt line
// - each source has its own mask bit; the mask is written as one whole word
// - sources: address match, overrun, break, parity, framing, timeout, tx, rx, modem lines
// - raw and masked interrupt status both readable
// - on transmit-bit disable the current character finishes on TXD_O, then FIFO is flushed; global disable idles TXD_O at once
package uart_ctl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_DMACTL = 8'h04;
    localparam logic [7:0] OFF_LEVEL  = 8'h08;
    localparam logic [7:0] OFF_MASK   = 8'h0c;
    localparam logic [7:0] OFF_RAW    = 8'h10;
    localparam logic [7:0] OFF_MSKD   = 8'h14;
    localparam logic [7:0] OFF_CLEAR  = 8'h18;

    ////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int CTRL_W         = 6;
    localparam int CTRL_GLOBAL    = 0;
    localparam int CTRL_TX        = 1;
    localparam int CTRL_RX        = 2;
    localparam int CTRL_FIFO      = 3;
    localparam int CTRL_IR        = 4;
    localparam int CTRL_IR_LP     = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    localparam int DMA_W          = 3;
    localparam int DMA_RX         = 0;
    localparam int DMA_TX         = 1;
    localparam int DMA_STOP       = 2;
    localparam logic [DMA_W-1:0] DMA_RESET = 3'h0;

    localparam int LVL_SEL_W      = 3;
    localparam int LVL_TX_LSB     = 0;
    localparam int LVL_RX_LSB     = 4;

    typedef enum logic [LVL_SEL_W-1:0] {
        LVL_1_8 = 3'b000,
        LVL_2_8 = 3'b001,
        LVL_4_8 = 3'b010,
        LVL_6_8 = 3'b011,
        LVL_7_8 = 3'b100
    } level_sel_t;
    localparam logic [LVL_SEL_W-1:0] LVL_RESET = 3'b010;

    ////////////////////////////////////////////////////////////////////////
    // interrupt source bit positions
    localparam int IRQ_W          = 12;
    localparam int IRQ_RING       = 0;
    localparam int IRQ_CTS        = 1;
    localparam int IRQ_DCD        = 2;
    localparam int IRQ_DSR        = 3;
    localparam int IRQ_RX         = 4;
    localparam int IRQ_TX         = 5;
    localparam int IRQ_TIMEOUT    = 6;
    localparam int IRQ_FRAMING    = 7;
    localparam int IRQ_PARITY     = 8;
    localparam int IRQ_BREAK      = 9;
    localparam int IRQ_OVERRUN    = 10;
    localparam int IRQ_ADDR_MATCH = 11;
    localparam logic [IRQ_W-1:0] IRQ_RX_ERR = 12'h780;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ          = 250;
    localparam int TICKS_PER_BIT    = 16;
    localparam int IR_PULSE_TICKS   = 3;
    localparam int IR_LP_PULSE_NS   = 1630;
    localparam int IR_LP_PULSE_CYC  = (IR_LP_PULSE_NS * CLK_MHZ + 999) / 1000;

endpackage

//--- hdl/uart_fifo_threshold.sv
// FIFO fill threshold crossing detector
`timescale 1ns/1ps
module uart_fifo_threshold #(
    parameter int DEPTH   = 16,
    parameter int LVL_W   = 5,
    parameter bit TX_SIDE = 1'b0
) (
    // clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               rst_n_i,
    // setting
    input  wire logic                               fifo_en_i,
    input  wire logic [uart_ctl_pkg::LVL_SEL_W-1:0] sel_i,
    // fill level
    input  wire logic [LVL_W-1:0]                   level_i,
    // crossing pulse
    output logic                                    crossed_o
);

    logic [LVL_W-1:0] thr;
    logic             cond;
    logic             cond_q;

    always_comb begin
        case (sel_i)
            uart_ctl_pkg::LVL_1_8: thr = LVL_W'(DEPTH * 1 / 8);
            uart_ctl_pkg::LVL_2_8: thr = LVL_W'(DEPTH * 2 / 8);
            uart_ctl_pkg::LVL_4_8: thr = LVL_W'(DEPTH * 4 / 8);
            uart_ctl_pkg::LVL_6_8: thr = LVL_W'(DEPTH * 6 / 8);
            default:               thr = LVL_W'(DEPTH * 7 / 8);
        endcase
    end

    // holding register mode: empty for transmit, one char for receive
    always_comb begin
        if (!fifo_en_i) begin
            cond = TX_SIDE ? (level_i == '0) : (level_i != '0);
        end else if (TX_SIDE) begin
            cond = (level_i <= thr);
        end else begin
            cond = (level_i >= thr) && (level_i != '0);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cond_q    <= 1'b1;
            crossed_o <= 1'b0;
        end else begin
            cond_q    <= cond;
            crossed_o <= cond & ~cond_q;
        end
    end

endmodule

//--- hdl/uart_irq_status.sv
// sticky interrupt status with mask and clear
`timescale 1ns/1ps
module uart_irq_status #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // events and software control
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    input  wire logic [W-1:0] mask_i,
    // status
    output logic [W-1:0]      raw_o,
    output logic [W-1:0]      masked_o,
    output logic              irq_o
);

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            raw_o <= '0;
        end else begin
            raw_o <= (raw_o & ~clr_i) | set_i;
        end
    end

    assign masked_o = raw_o & mask_i;
    assign irq_o    = |masked_o;

endmodule

//--- tb/uart_ctl_props.sv
// port assertions for the serial port control plane
`timescale 1ns/1ps
module uart_ctl_props #(
    parameter int DEPTH = 16,
    parameter int LVL_W = 5
) (
    // clock, reset, bus
    input wire logic             REF_CLK_I,
    input wire logic             RST_N_I,
    input wire logic             PSEL_I,
    input wire logic             PENABLE_I,
    input wire logic             PWRITE_I,
    input wire logic             PREADY_O,
    input wire logic             PSLVERR_O,
    // datapath and outputs
    input wire logic [LVL_W-1:0] TX_LEVEL_I,
    input wire logic [LVL_W-1:0] RX_LEVEL_I,
    input wire logic             TX_BUSY_I,
    input wire logic             TX_ENABLE_O,
    input wire logic             RX_ENABLE_O,
    input wire logic             FIFO_ENABLE_O,
    input wire logic             TX_FLUSH_O,
    input wire logic             TX_DMA_REQ_O,
    input wire logic             RX_DMA_REQ_O,
    input wire logic             IRQ_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_ready_always: assert property (PSEL_I |-> PREADY_O) else $error("bus not ready");
    a_error_access: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I) else $error("error outside access");
    a_rx_dma_gate: assert property (RX_DMA_REQ_O |-> RX_ENABLE_O && RX_LEVEL_I != 0)
        else $error("rx request without data");
    a_tx_dma_gate: assert property (TX_DMA_REQ_O |-> TX_ENABLE_O) else $error("tx request while off");
    a_tx_dma_full: assert property (FIFO_ENABLE_O && TX_LEVEL_I >= DEPTH |-> !TX_DMA_REQ_O)
        else $error("tx request with full fifo");
    a_flush_single: assert property (TX_FLUSH_O |=> !TX_FLUSH_O) else $error("flush too long");
    a_flush_stops: assert property (TX_FLUSH_O |-> !TX_ENABLE_O && $past(TX_ENABLE_O))
        else $error("flush without stop");
    a_busy_holds: assert property (TX_ENABLE_O && TX_BUSY_I |=> TX_ENABLE_O)
        else $error("tx stopped mid character");
    a_irq_sticky: assert property (IRQ_O && !(PSEL_I && PENABLE_I && PWRITE_I) |=> IRQ_O)
        else $error("irq dropped without write");

    c_flush: cover property (TX_FLUSH_O);
    c_irq: cover property ($rose(IRQ_O));
    c_dma: cover property (RX_DMA_REQ_O && TX_DMA_REQ_O);
endmodule

bind uart_ctl_top uart_ctl_props #(.DEPTH(DEPTH), .LVL_W(LVL_W)) props_u (.*);

//--- tb/uart_far_model.sv
// far-side serial partner: idle line and modem status pins
`timescale 1ns/1ps
module uart_far_model (
    // bench control
    input  wire logic ring_i,
    // pins toward the port
    output logic      rxd_o,
    output logic      dsr_n_o,
    output logic      dcd_n_o,
    output logic      cts_n_o,
    output logic      ri_n_o
);
    // idle mark, modem lines inactive unless ringing
    assign rxd_o = 1'b1;
    assign dsr_n_o = 1'b1;
    assign dcd_n_o = 1'b1;
    assign cts_n_o = 1'b1;
    assign ri_n_o = ~ring_i;
endmodule

//--- tb/tb_top.sv
// self-checking bench for the serial port control plane
`timescale 1ns/1ps
module tb_top;
    logic        REF_CLK_I, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, TX_BUSY_I, ring, er, tx_ser, tick;
    logic        PREADY_O, PSLVERR_O, TXD_O, TX_ENABLE_O, RX_ENABLE_O, FIFO_ENABLE_O, TX_FLUSH_O;
    logic        RX_SERIAL_O, TX_DMA_REQ_O, RX_DMA_REQ_O, IRQ_O, RXD_I, DSR_N_I, DCD_N_I, CTS_N_I, RI_N_I;
    logic [7:0]  PADDR_I;
    logic [31:0] PWDATA_I, PRDATA_O, rd, lf, m_raw;
    logic [4:0]  TX_LEVEL_I, RX_LEVEL_I;
    logic [5:0]  evt;
    int          bad_count, total_checks, i;

    uart_ctl_top #(.LP_CYCLES(4)) dut_u (.*, .TX_SERIAL_I(tx_ser), .BAUD16_TICK_I(tick),
        .EVT_ADDR_MATCH_I(evt[5]), .EVT_OVERRUN_I(evt[4]), .EVT_BREAK_I(evt[3]),
        .EVT_PARITY_I(evt[2]), .EVT_FRAMING_I(evt[1]), .EVT_TIMEOUT_I(evt[0]));
    uart_far_model far_u (.ring_i(ring), .rxd_o(RXD_I), .dsr_n_o(DSR_N_I), .dcd_n_o(DCD_N_I),
        .cts_n_o(CTS_N_I), .ri_n_o(RI_N_I));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle;
        repeat (4) @(posedge REF_CLK_I);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL_I <= 1'b1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge REF_CLK_I);
        PENABLE_I <= 1'b1;
        do begin
            @(posedge REF_CLK_I);
            n++;
        end while (PREADY_O !== 1'b1 && n < 20);
        rd = PRDATA_O;
        er = PSLVERR_O;
        if (n >= 20) begin
            bad_count++;
            stop_test();
        end
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
        @(posedge REF_CLK_I);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp & m);
    endtask
    task automatic pulse(input logic [5:0] e);
        evt <= e;
        @(posedge REF_CLK_I);
        evt <= 6'h00;
        m_raw = m_raw | {e, 6'h00};
        settle();
    endtask

    initial begin
        REF_CLK_I = 1'b0;
        forever #2 REF_CLK_I = ~REF_CLK_I;
    end
    initial begin
        repeat (20000) @(posedge REF_CLK_I);
        bad_count++;
        stop_test();
    end
    initial begin
        {RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, TX_BUSY_I, ring, tick, evt} = '0;
        tx_ser = 1'b1;
        PADDR_I = 8'h00;
        PWDATA_I = 32'h0;
        TX_LEVEL_I = 5'h04;
        RX_LEVEL_I = 5'h00;
        lf = 32'he6dd;
        m_raw = 32'h0;
        repeat (16) @(posedge REF_CLK_I);
        RST_N_I <= 1'b1;
        @(posedge REF_CLK_I);
        rdc(8'h00, 32'h0, '1);
        rdc(8'h04, 32'h0, '1);
        rdc(8'h08, 32'h22, '1);
        for (i = 0; i < 5; i++) begin
            apb(1'b1, 8'h08, 32'((4 - i) << 4 | i));
            rdc(8'h08, 32'((4 - i) << 4 | i), '1);
        end
        $display("test thresholds done");
        apb(1'b1, 8'h00, 32'h0f);
        settle();
        chk({TX_ENABLE_O, RX_ENABLE_O, FIFO_ENABLE_O}, 32'h7);
        apb(1'b1, 8'h00, 32'h37);
        rdc(8'h00, 32'h37, '1);
        chk(FIFO_ENABLE_O, 32'h0);
        chk({TXD_O, RX_SERIAL_O}, 32'h1);
        tx_ser <= 1'b0;
        tick <= 1'b1;
        @(posedge REF_CLK_I);
        tick <= 1'b0;
        i = 0;
        repeat (12) @(negedge REF_CLK_I) i += TXD_O;
        chk(i, 32'd4);
        @(posedge REF_CLK_I);
        tx_ser <= 1'b1;
        apb(1'b1, 8'h00, 32'h0f);
        lf = lfsr(lf);
        RX_LEVEL_I <= {1'b0, lf[3:0] | 4'h1};
        TX_LEVEL_I <= {1'b0, lf[7:4]};
        apb(1'b1, 8'h04, 32'h3);
        settle();
        chk({TX_DMA_REQ_O, RX_DMA_REQ_O}, 32'h3);
        apb(1'b1, 8'h04, 32'h2);
        settle();
        chk({TX_DMA_REQ_O, RX_DMA_REQ_O}, 32'h2);
        apb(1'b1, 8'h04, 32'h5);
        pulse(6'h04);
        chk({TX_DMA_REQ_O, RX_DMA_REQ_O}, 32'h0);
        apb(1'b1, 8'h18, 32'h780);
        settle();
        chk({TX_DMA_REQ_O, RX_DMA_REQ_O}, 32'h1);
        $display("test dma done");
        apb(1'b1, 8'h18, 32'hfff);
        m_raw = 32'h0;
        RX_LEVEL_I <= 5'h1;
        TX_LEVEL_I <= 5'h0f;
        settle();
        rdc(8'h10, 32'h0, 32'h30);
        RX_LEVEL_I <= 5'h2;
        TX_LEVEL_I <= 5'h0e;
        settle();
        rdc(8'h10, 32'h30, 32'h30);
        apb(1'b1, 8'h0c, 32'hfc1);
        pulse(6'h3f);
        rdc(8'h10, m_raw, 32'hfc1);
        chk(IRQ_O, 32'h1);
        apb(1'b1, 8'h18, 32'h100);
        m_raw = m_raw & ~32'h100;
        rdc(8'h10, m_raw, 32'hfc1);
        apb(1'b1, 8'h0c, 32'h041);
        rdc(8'h14, m_raw & 32'h041, '1);
        apb(1'b1, 8'h18, 32'h040);
        settle();
        chk(IRQ_O, 32'h0);
        ring <= 1'b1;
        repeat (6) @(posedge REF_CLK_I);
        chk(IRQ_O, 32'h1);
        apb(1'b1, 8'h18, 32'h001);
        settle();
        chk(IRQ_O, 32'h0);
        $display("test interrupts done");
        TX_BUSY_I <= 1'b1;
        apb(1'b1, 8'h00, 32'h0);
        settle();
        chk(TX_ENABLE_O, 32'h1);
        TX_BUSY_I <= 1'b0;
        i = 0;
        while (TX_FLUSH_O !== 1'b1 && i < 10) begin
            @(negedge REF_CLK_I);
            i++;
        end
        chk({i < 10, TX_ENABLE_O}, 32'h2);
        @(posedge REF_CLK_I);
        apb(1'b0, 8'h1c, 32'h0);
        chk({er, rd[0]}, 32'h2);
        apb(1'b1, 8'h10, 32'hfff);
        chk(er, 32'h1);
        $display("test stop and refusals done");
        stop_test();
    end
endmodule
